// ==== src/fau_float_add_unit.sv ====
/*
 * floating add datapath with sum, low-order and operand holding registers,
 * reached as a classic wishbone slave with 32-bit data.
 * assumes software writes the memory operand before starting an add.
 */
// Added by the designer: the Wishbone register port and the register offsets.
// Summary of operation
// - clear low-order, then load holding register
// - exchange when holding characteristic is smaller
// - low-order sign copies sum sign
// - difference over 63 clears, else shift
// - sum position 35 feeds low-order 9
// - holding characteristic goes into sum
// - add fractions, ones complement if unlike
// - like-sign carry bumps characteristic, shifts right
// - unlike, holding larger: take holding sign
// - unlike, holding smaller: plain difference
// - zero result becomes normal zero
// - unnormalized zero takes smaller-operand sign
// - shift left until position 9 set
// - low-order characteristic is sum minus 27
// - add raises underflow, overflow and trap
// - add finishes within 6 to 13 cycles
// - guard bits force exchange, sign merge
// - upper guard lost, guards cleared
// - difference taken after the exchange
// - magnitude add forces operand positive
// - sign, 8-bit characteristic, 27-bit fraction
module fau_float_add_unit (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // indicator
  output logic fp_trap_o
);
  import fau_pkg::*;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [5:0] fau_lead_zeros(input logic [53:0] v);
    logic [5:0] n;
    logic hit;
    n = '0;
    hit = 1'b0;
    for (int i = 53; i >= 0; i--) begin
      if (!hit && v[i]) begin
        hit = 1'b1;
      end else if (!hit) begin
        n = n + 6'h01;
      end
    end
    return n;
  endfunction

  function automatic logic [31:0] fau_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  fau_state_t state_q, state_d;
  logic [37:0] ac_q, ac_d;
  logic [35:0] mq_q, mq_d, sr_q, sr_d, opnd_q, opnd_d;
  logic mag_q, mag_d, orig_sign_q, orig_sign_d, small_sign_q, small_sign_d, norm_in_q, norm_in_d;
  logic unf_q, unf_d, ovf_q, ovf_d, trap_q, trap_d;
  logic ack_q, ack_d;
  logic [31:0] dat_q, dat_d;

  logic access, wr, start, unf_set, ovf_set;
  logic [31:0] hi_old, rdata;
  logic [7:0] diff, ac_char;
  logic [53:0] pair;
  logic [27:0] sum28;
  logic [5:0] lz, step;
  logic swap_need, like;

  always_comb begin
    state_d = state_q;
    ac_d = ac_q;
    mq_d = mq_q;
    sr_d = sr_q;
    opnd_d = opnd_q;
    mag_d = mag_q;
    orig_sign_d = orig_sign_q;
    small_sign_d = small_sign_q;
    norm_in_d = norm_in_q;
    unf_set = 1'b0;
    ovf_set = 1'b0;
    hi_old = '0;
    rdata = '0;
    diff = '0;
    pair = '0;
    sum28 = '0;
    lz = '0;
    step = '0;
    swap_need = 1'b0;
    like = 1'b0;
    ac_char = ac_q[CHAR_MSB:CHAR_LSB];
    // ************************************************************
    // bus slave
    // ************************************************************
    access = wb_cyc_i && wb_stb_i && !ack_q;
    // writes land on the edge where the master samples ack, and only while idle
    wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && (state_q == FAU_IDLE);
    start = 1'b0;
    unique case (wb_adr_i)
      OFS_CTRL: rdata[STAT_BUSY] = (state_q != FAU_IDLE);
      OFS_STAT: rdata = {28'h000_0000, trap_q, ovf_q, unf_q, state_q != FAU_IDLE};
      OFS_SUM_LO: rdata = ac_q[31:0];
      OFS_SUM_HI: rdata = {26'h000_0000, ac_q[GUARD_Q], ac_q[GUARD_P], ac_q[35:32]};
      OFS_LOW_LO: rdata = mq_q[31:0];
      OFS_LOW_HI: rdata = {28'h000_0000, mq_q[35:32]};
      OFS_OPND_LO: rdata = opnd_q[31:0];
      OFS_OPND_HI: rdata = {28'h000_0000, opnd_q[35:32]};
      OFS_HOLD_LO: rdata = sr_q[31:0];
      OFS_HOLD_HI: rdata = {28'h000_0000, sr_q[35:32]};
      default: rdata = '0;
    endcase
    ack_d = access;
    dat_d = access ? rdata : dat_q;
    if (wr && state_q == FAU_IDLE) begin
      unique case (wb_adr_i)
        OFS_CTRL: begin
          start = wb_sel_i[0] && (wb_dat_i[CTRL_ADD] || wb_dat_i[CTRL_MAG]);
          mag_d = wb_dat_i[CTRL_MAG];
        end
        OFS_SUM_LO: ac_d[31:0] = fau_merge(ac_q[31:0], wb_dat_i, wb_sel_i);
        OFS_SUM_HI: begin
          hi_old = fau_merge({26'h000_0000, ac_q[GUARD_Q], ac_q[GUARD_P], ac_q[35:32]}, wb_dat_i, wb_sel_i);
          ac_d[37:32] = hi_old[5:0];
        end
        OFS_LOW_LO: mq_d[31:0] = fau_merge(mq_q[31:0], wb_dat_i, wb_sel_i);
        OFS_LOW_HI: begin
          hi_old = fau_merge({28'h000_0000, mq_q[35:32]}, wb_dat_i, wb_sel_i);
          mq_d[35:32] = hi_old[3:0];
        end
        OFS_OPND_LO: opnd_d[31:0] = fau_merge(opnd_q[31:0], wb_dat_i, wb_sel_i);
        OFS_OPND_HI: begin
          hi_old = fau_merge({28'h000_0000, opnd_q[35:32]}, wb_dat_i, wb_sel_i);
          opnd_d[35:32] = hi_old[3:0];
        end
        default: ;
      endcase
    end
    // ************************************************************
    // add sequencer
    // ************************************************************
    unique case (state_q)
      FAU_IDLE: begin
        if (start) begin
          mq_d = '0;
          state_d = FAU_LOAD;
        end
      end
      FAU_LOAD: begin
        sr_d = opnd_q;
        if (mag_q) begin
          sr_d[SIGN_BIT] = 1'b0;
        end
        orig_sign_d = ac_q[SIGN_BIT];
        norm_in_d = ac_q[FRAC_MSB] && opnd_q[FRAC_MSB];
        state_d = FAU_SWAP;
      end
      FAU_SWAP: begin
        swap_need = (ac_q[GUARD_Q:GUARD_P] != 2'b00) ||
                    ({2'b00, sr_q[CHAR_MSB:CHAR_LSB]} < {ac_q[GUARD_Q:GUARD_P], ac_char});
        if (swap_need) begin
          sr_d = {ac_q[SIGN_BIT] | ac_q[GUARD_P], ac_q[CHAR_MSB:0]};
          ac_d = {2'b00, sr_q};
        end
        mq_d[SIGN_BIT] = swap_need ? sr_q[SIGN_BIT] : ac_q[SIGN_BIT];
        small_sign_d = swap_need ? sr_q[SIGN_BIT] : ac_q[SIGN_BIT];
        state_d = FAU_ALIGN;
      end
      FAU_ALIGN: begin
        diff = sr_q[CHAR_MSB:CHAR_LSB] - ac_char;
        if (diff > ALIGN_LIMIT) begin
          ac_d[FRAC_MSB:0] = '0;
        end else begin
          pair = {ac_q[FRAC_MSB:0], mq_q[FRAC_MSB:0]} >> diff;
          ac_d[FRAC_MSB:0] = pair[53:27];
          mq_d[FRAC_MSB:0] = pair[26:0];
        end
        ac_d[CHAR_MSB:CHAR_LSB] = sr_q[CHAR_MSB:CHAR_LSB];
        state_d = FAU_ADD;
      end
      FAU_ADD: begin
        like = (ac_q[SIGN_BIT] == sr_q[SIGN_BIT]);
        sum28 = {1'b0, sr_q[FRAC_MSB:0]} + {1'b0, like ? ac_q[FRAC_MSB:0] : ~ac_q[FRAC_MSB:0]};
        if (like) begin
          if (sum28[27]) begin
            ac_d[CHAR_MSB:CHAR_LSB] = ac_char + 8'h01;
            ovf_set = (ac_char == CHAR_MAX);
            ac_d[FRAC_MSB:0] = {1'b1, sum28[26:1]};
            mq_d[FRAC_MSB:0] = {sum28[0], mq_q[FRAC_MSB:1]};
          end else begin
            ac_d[FRAC_MSB:0] = sum28[26:0];
          end
        end else if (sum28[27]) begin
          // holding larger: its sign, borrow from low-order
          ac_d[SIGN_BIT] = sr_q[SIGN_BIT];
          mq_d[SIGN_BIT] = sr_q[SIGN_BIT];
          if (mq_q[FRAC_MSB:0] == '0) begin
            ac_d[FRAC_MSB:0] = sum28[26:0] + 27'h000_0001;
          end else begin
            ac_d[FRAC_MSB:0] = sum28[26:0];
            mq_d[FRAC_MSB:0] = ~mq_q[FRAC_MSB:0] + 27'h000_0001;
          end
        end else begin
          ac_d[FRAC_MSB:0] = ~sum28[26:0];
        end
        state_d = FAU_FIX;
      end
      FAU_FIX: begin
        if (ac_q[FRAC_MSB:0] == '0 && mq_q[FRAC_MSB:0] == '0) begin
          ac_d = '0;
          ac_d[SIGN_BIT] = norm_in_q ? orig_sign_q : small_sign_q;
          mq_d[SIGN_BIT] = norm_in_q ? orig_sign_q : small_sign_q;
          state_d = FAU_CHAR;
        end else begin
          state_d = ac_q[FRAC_MSB] ? FAU_CHAR : FAU_NORM;
        end
      end
      FAU_NORM: begin
        // left shift, up to eight places a cycle
        lz = fau_lead_zeros({ac_q[FRAC_MSB:0], mq_q[FRAC_MSB:0]});
        step = (lz > NORM_STEP) ? NORM_STEP : lz;
        pair = {ac_q[FRAC_MSB:0], mq_q[FRAC_MSB:0]} << step;
        ac_d[FRAC_MSB:0] = pair[53:27];
        mq_d[FRAC_MSB:0] = pair[26:0];
        ac_d[CHAR_MSB:CHAR_LSB] = ac_char - {2'b00, step};
        unf_set = ({2'b00, step} > ac_char);
        state_d = (lz > NORM_STEP) ? FAU_NORM : FAU_CHAR;
      end
      FAU_CHAR: begin
        if (ac_q[CHAR_MSB:0] == '0) begin
          mq_d[CHAR_MSB:CHAR_LSB] = '0;
        end else begin
          mq_d[CHAR_MSB:CHAR_LSB] = ac_char - LOW_CHAR_OFS;
          unf_set = (ac_char < LOW_CHAR_OFS);
        end
        state_d = FAU_IDLE;
      end
    endcase
    unf_d = (unf_q && !(wr && wb_adr_i == OFS_STAT && wb_sel_i[0] && wb_dat_i[STAT_UNF])) || unf_set;
    ovf_d = (ovf_q && !(wr && wb_adr_i == OFS_STAT && wb_sel_i[0] && wb_dat_i[STAT_OVF])) || ovf_set;
    trap_d = (trap_q && !(wr && wb_adr_i == OFS_STAT && wb_sel_i[0] && wb_dat_i[STAT_TRAP])) || unf_set || ovf_set;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q <= FAU_IDLE;
      ac_q <= '0;
      mq_q <= '0;
      sr_q <= '0;
      opnd_q <= '0;
      mag_q <= 1'b0;
      orig_sign_q <= 1'b0;
      small_sign_q <= 1'b0;
      norm_in_q <= 1'b0;
      unf_q <= 1'b0;
      ovf_q <= 1'b0;
      trap_q <= 1'b0;
      ack_q <= 1'b0;
      dat_q <= '0;
    end else begin
      state_q <= state_d;
      ac_q <= ac_d;
      mq_q <= mq_d;
      sr_q <= sr_d;
      opnd_q <= opnd_d;
      mag_q <= mag_d;
      orig_sign_q <= orig_sign_d;
      small_sign_q <= small_sign_d;
      norm_in_q <= norm_in_d;
      unf_q <= unf_d;
      ovf_q <= ovf_d;
      trap_q <= trap_d;
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign fp_trap_o = trap_q;

  // ************************************************************
  // assertions
  // ************************************************************
  sequence s_run_done;
    (state_q != FAU_IDLE) [*5] ##[1:9] (state_q == FAU_IDLE);
  endsequence

  a_run_length: assert property (@(posedge clock) disable iff (!nrst)
    (state_q == FAU_IDLE && state_d == FAU_LOAD) |=> s_run_done) else $error("add ran out of bounds");
  a_low_cleared: assert property (@(posedge clock) disable iff (!nrst)
    (state_q == FAU_IDLE && state_d == FAU_LOAD) |=> (mq_q == '0)) else $error("low-order not cleared");
  a_hold_loaded: assert property (@(posedge clock) disable iff (!nrst)
    (state_q == FAU_LOAD) |=> (sr_q[CHAR_MSB:0] == $past(opnd_q[CHAR_MSB:0])) &&
    (sr_q[SIGN_BIT] == ($past(opnd_q[SIGN_BIT]) && !mag_q))) else $error("holding load wrong");
  a_swap_order: assert property (@(posedge clock) disable iff (!nrst)
    (state_q == FAU_SWAP) |=> ($past(ac_q[GUARD_Q:GUARD_P]) != 2'b00 ||
    sr_q[CHAR_MSB:CHAR_LSB] >= ac_q[CHAR_MSB:CHAR_LSB]) &&
    (ac_q[GUARD_Q:GUARD_P] == 2'b00)) else $error("exchange left order wrong");
  a_low_sign: assert property (@(posedge clock) disable iff (!nrst)
    (state_q == FAU_SWAP) |=> (mq_q[SIGN_BIT] == ac_q[SIGN_BIT])) else $error("low-order sign differs");
  a_align_char: assert property (@(posedge clock) disable iff (!nrst)
    (state_q == FAU_ALIGN) |=> (ac_q[CHAR_MSB:CHAR_LSB] == $past(sr_q[CHAR_MSB:CHAR_LSB]))) else $error("char not set");
  a_normal_end: assert property (@(posedge clock) disable iff (!nrst)
    (state_q == FAU_CHAR) |-> (ac_q[FRAC_MSB] || ac_q[CHAR_MSB:0] == '0)) else $error("result not normalized");
  a_low_char: assert property (@(posedge clock) disable iff (!nrst)
    (state_q == FAU_CHAR && ac_q[CHAR_MSB:0] != '0) |=>
    (mq_q[CHAR_MSB:CHAR_LSB] == ac_q[CHAR_MSB:CHAR_LSB] - LOW_CHAR_OFS)) else $error("low char wrong");
  a_signs_equal: assert property (@(posedge clock) disable iff (!nrst)
    (state_q == FAU_CHAR) |-> (mq_q[SIGN_BIT] == ac_q[SIGN_BIT])) else $error("signs differ at end");
  a_trap_follows: assert property (@(posedge clock) disable iff (!nrst)
    (unf_set || ovf_set) |=> fp_trap_o && (unf_q || ovf_q)) else $error("trap not raised");
  a_ack_pulse: assert property (@(posedge clock) disable iff (!nrst)
    wb_ack_o |=> !wb_ack_o) else $error("ack longer than a cycle");
endmodule

// ==== src/fau_pkg.sv ====
/*
 * constants of the floating add unit: register map, word fields, timing.
 * assumes 36-bit words with the sign in bit 35 and two guard bits above.
 */
package fau_pkg;
  // ************************************************************
  // word layout
  // ************************************************************
  localparam int WORD_W = 36;
  localparam int FRAC_W = 27;
  localparam int SIGN_BIT = 35;
  localparam int CHAR_MSB = 34;
  localparam int CHAR_LSB = 27;
  localparam int FRAC_MSB = 26;
  localparam int GUARD_Q = 37;
  localparam int GUARD_P = 36;
  localparam logic [7:0] CHAR_MAX = 8'h00_FF;
  localparam logic [7:0] ALIGN_LIMIT = 8'h00_3F;
  localparam logic [7:0] LOW_CHAR_OFS = 8'h00_1B;
  localparam logic [5:0] NORM_STEP = 6'h08;
  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00_00;
  localparam logic [7:0] OFS_STAT = 8'h00_04;
  localparam logic [7:0] OFS_SUM_LO = 8'h00_08;
  localparam logic [7:0] OFS_SUM_HI = 8'h00_0C;
  localparam logic [7:0] OFS_LOW_LO = 8'h00_10;
  localparam logic [7:0] OFS_LOW_HI = 8'h00_14;
  localparam logic [7:0] OFS_OPND_LO = 8'h00_18;
  localparam logic [7:0] OFS_OPND_HI = 8'h00_1C;
  localparam logic [7:0] OFS_HOLD_LO = 8'h00_20;
  localparam logic [7:0] OFS_HOLD_HI = 8'h00_24;
  // ************************************************************
  // control and status bits
  // ************************************************************
  localparam int CTRL_ADD = 0;
  localparam int CTRL_MAG = 1;
  localparam int STAT_BUSY = 0;
  localparam int STAT_UNF = 1;
  localparam int STAT_OVF = 2;
  localparam int STAT_TRAP = 3;
  localparam int HI_P = 4;
  localparam int HI_Q = 5;
  localparam int MIN_CYCLES = 6;
  localparam int MAX_CYCLES = 15;
  typedef enum logic [2:0] {
    FAU_IDLE = 3'b000,
    FAU_LOAD = 3'b001,
    FAU_SWAP = 3'b010,
    FAU_ALIGN = 3'b011,
    FAU_ADD = 3'b100,
    FAU_FIX = 3'b101,
    FAU_NORM = 3'b110,
    FAU_CHAR = 3'b111
  } fau_state_t;
endpackage

// ==== tb/fau_seq_model.sv ====
/*
 * sequencer model: classic wishbone master standing in for the processor side.
 * assumes a slave that acks each request; a wait gives up after 64 edges.
 */
module fau_seq_model (
  // clock
  input wire logic clock,
  // wishbone master
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [7:0] adr,
  output logic [3:0] sel,
  output logic [31:0] dat_w,
  input wire logic [31:0] dat_r,
  input wire logic ack,
  // wait limit ran out
  output logic hung
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat_w = 32'h0000_0000;
    hung = 1'b0;
  end
  // ************************************************************
  // one classic cycle, launched and released on rising edges
  // ************************************************************
  task automatic access(input logic wr, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d,
                        output logic [31:0] rdat);
    int n;
    n = 0;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    sel <= s;
    dat_w <= d;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 64);
    if (ack !== 1'b1) hung = 1'b1;
    rdat = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    // inverted so stale write data is never mistaken for a fresh value
    dat_w <= ~d;
  endtask
endmodule

// ==== tb/fau_float_add_unit_tb.sv ====
/*
 * self-checking bench of the floating add unit: random adds and corner cases.
 * assumes the sequencer model as bus master and a 100 MHz clock.
 */
module fau_float_add_unit_tb
  import fau_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin fails++; \
    $display("Error %0t: got %h exp %h", $time, got, exp); end end
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic cyc, stb, we, ack, trap, hung;
  logic [7:0] adr, c, d8;
  logic [3:0] sel;
  logic [31:0] dat_w, dat_r, q;
  logic [35:0] w, a, b, e_sum, e_low, e_hold;
  int fails = 0;
  int n_checks = 0;
  int seed = 42;
  always #5 clock = ~clock;
  fau_float_add_unit fau_float_add_unit_i (.clock(clock), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .fp_trap_o(trap));
  fau_seq_model fau_seq_model_i (.clock(clock), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
    .dat_w(dat_w), .dat_r(dat_r), .ack(ack), .hung(hung));
  // ************************************************************
  // expected result of a normalized add of normalized operands
  // ************************************************************
  function automatic void fad_ref(input logic [35:0] ac, input logic [35:0] sr, input logic mag,
                                  output logic [35:0] sum, output logic [35:0] low, output logic [35:0] hold);
    logic [35:0] t;
    logic [53:0] f;
    logic [27:0] s;
    logic [7:0] ch;
    logic sg, s0;
    int d;
    if (mag) sr[35] = 1'b0;
    s0 = ac[35];
    if (sr[34:27] < ac[34:27]) begin
      t = sr;
      sr = ac;
      ac = t;
    end
    hold = sr;
    d = int'(sr[34:27]) - int'(ac[34:27]);
    f = (d > 63) ? 54'h0 : {ac[26:0], 27'h0} >> d;
    ch = sr[34:27];
    sg = ac[35];
    if (ac[35] == sr[35]) begin
      s = {1'b0, f[53:27]} + {1'b0, sr[26:0]};
      f[53:27] = s[26:0];
      if (s[27]) begin
        f = {1'b1, f[53:1]};
        ch = ch + 8'h01;
      end
    end else if (sr[26:0] > f[53:27]) begin
      sg = sr[35];
      f[53:27] = sr[26:0] - f[53:27] - 27'(f[26:0] != 27'h0);
      f[26:0] = -f[26:0];
    end else begin
      f[53:27] = f[53:27] - sr[26:0];
    end
    sum = {s0, 35'h0};
    low = sum;
    if (f == 54'h0) return;
    while (!f[53]) begin
      f = f << 1;
      ch = ch - 8'h01;
    end
    sum = {sg, ch, f[53:27]};
    low = {sg, ch - LOW_CHAR_OFS, f[26:0]};
  endfunction
  // ************************************************************
  // bus helpers
  // ************************************************************
  task automatic tally_and_finish();
    if (hung) fails++;
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] dd);
    fau_seq_model_i.access(1'b1, ad, 4'hF, dd, q);
  endtask
  task automatic stat();
    fau_seq_model_i.access(1'b0, OFS_STAT, 4'hF, 32'h0000_0000, q);
  endtask
  task automatic rd(input logic [7:0] ad, output logic [35:0] v);
    logic [31:0] lo;
    fau_seq_model_i.access(1'b0, ad, 4'hF, 32'h0000_0000, lo);
    fau_seq_model_i.access(1'b0, ad + 8'h04, 4'hF, 32'h0000_0000, q);
    v = {q[3:0], lo};
  endtask
  task automatic wait_idle(output int n);
    n = 0;
    do begin
      stat();
      n++;
    end while (q[STAT_BUSY] !== 1'b0 && n < 20);
    if (q[STAT_BUSY] !== 1'b0 || hung) begin
      fails++;
      tally_and_finish();
    end
  endtask
  task automatic go(input logic [35:0] x, input logic [1:0] gd, input logic [35:0] y, input logic mag);
    int n;
    wr(OFS_OPND_LO, y[31:0]);
    wr(OFS_OPND_HI, {28'h0, y[35:32]});
    wr(OFS_SUM_LO, x[31:0]);
    wr(OFS_SUM_HI, {26'h0, gd, x[35:32]});
    wr(OFS_LOW_LO, 32'hFFFF_FFFF);
    wr(OFS_LOW_HI, 32'h0000_000F);
    wr(OFS_CTRL, mag ? 32'h0000_0003 : 32'h0000_0001);
    wait_idle(n);
    // each status poll spans three cycles; the add starts on the write's ack edge
    `CHK(n >= (MIN_CYCLES + 1) / 3 + 1 && n <= (MAX_CYCLES + 1) / 3 + 1, 1'b1)
  endtask
  task automatic chk_add(input logic [35:0] x, input logic [35:0] y, input logic mag);
    fad_ref(x, y, mag, e_sum, e_low, e_hold);
    go(x, 2'b00, y, mag);
    rd(OFS_SUM_LO, w);
    `CHK(w, e_sum)
    rd(OFS_LOW_LO, w);
    `CHK(w, e_low)
    rd(OFS_HOLD_LO, w);
    `CHK(w, e_hold)
    stat();
    `CHK({q[3:0], trap}, 5'h00)
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    rd(OFS_SUM_LO, w);
    `CHK(w, 36'h0_0000_0000)
    fau_seq_model_i.access(1'b0, 8'hFC, 4'hF, 32'h0000_0000, q);
    `CHK(q, 32'h0000_0000)
    // equal magnitudes of unlike sign cancel to a normal zero
    w = {1'b0, 8'h80, 1'b1, 26'h155_5555};
    chk_add(w, {1'b1, w[34:0]}, 1'b0);
    for (int i = 0; i < 60; i++) begin
      c = 8'h64 + (8'($random(seed)) & 8'h3F);
      d8 = (i % 5 == 0) ? 8'h46 : (8'($random(seed)) & 8'h07) - 8'h03;
      a = {1'($random(seed)), c, 1'b1, 26'($random(seed))};
      b = {1'($random(seed)), c + d8, 1'b1, 26'($random(seed))};
      chk_add(a, b, 1'($random(seed)));
    end
    for (int k = 0; k < 2; k++) begin
      w = {1'b0, k ? 8'h0A : 8'hFF, 27'h400_0000};
      go(w, 2'b00, w, 1'b0);
      stat();
      `CHK({q[STAT_TRAP], q[k ? STAT_UNF : STAT_OVF], trap}, 3'b111)
      wr(OFS_STAT, 32'h0000_000E);
      stat();
      `CHK({q[3:0], trap}, 5'h00)
    end
    // cancelling unnormalized operands take the smaller operand's sign
    go({1'b0, 8'h10, 27'h000_0100}, 2'b00, {1'b1, 8'h0F, 27'h000_0200}, 1'b0);
    rd(OFS_SUM_LO, w);
    `CHK(w, {1'b1, 35'h0})
    rd(OFS_LOW_LO, w);
    `CHK(w, {1'b1, 35'h0})
    // guard bits force the exchange and the P guard merges into the sign
    go({1'b0, 8'h10, 27'h400_0000}, 2'b11, {1'b0, 8'h80, 27'h400_0000}, 1'b0);
    rd(OFS_HOLD_LO, w);
    `CHK(w[35], 1'b1)
    rd(OFS_SUM_LO, w);
    `CHK(q[HI_Q:HI_P], 2'b00)
    wr(OFS_OPND_LO, 32'h2345_6789);
    fau_seq_model_i.access(1'b1, OFS_CTRL, 4'b0010, 32'h0000_0001, q);
    stat();
    `CHK(q[STAT_BUSY], 1'b0)
    wr(OFS_CTRL, 32'h0000_0001);
    wr(OFS_OPND_LO, 32'h0000_0000);
    wait_idle(seed);
    rd(OFS_OPND_LO, w);
    `CHK(w[31:0], 32'h2345_6789)
    tally_and_finish();
  end
endmodule
